// [design/ivp_pkg.sv]
// constants and carrier types for the interrupt vector and priority block
package ivp_pkg;

  // ==========================================================================
  // sizes
  localparam int NODES      = 14;
  localparam int CRIT_SRCS  = 6;
  localparam int NMI_SLOT   = 4;

  // ==========================================================================
  // vectors
  localparam logic [15:0] NMI_VECTOR   = 16'h0073;
  localparam logic [15:0] NODE5_VECTOR = 16'h002b;
  localparam logic [2:0]  VEC_LOW_BITS = 3'h3;
  localparam logic [15:0] VEC_FIRST    = 16'h0003;
  localparam logic [15:0] VEC_LAST     = 16'h006b;
  localparam logic [3:0]  NODE_TIMER2  = 4'h5;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFS_CRIT_CTRL  = 8'h00;
  localparam logic [7:0] OFS_EN_LOW     = 8'h04;
  localparam logic [7:0] OFS_EN_HIGH    = 8'h08;
  localparam logic [7:0] OFS_PRIO_LO_A  = 8'h0c;
  localparam logic [7:0] OFS_PRIO_HI_A  = 8'h10;
  localparam logic [7:0] OFS_PRIO_LO_B  = 8'h14;
  localparam logic [7:0] OFS_PRIO_HI_B  = 8'h18;
  localparam logic [7:0] OFS_STATUS     = 8'h1c;

  // ==========================================================================
  // field layout: group a holds nodes 0..6, group b nodes 7..13
  localparam int EN_LOW_NODES  = 6;
  localparam int EN_HIGH_NODES = 8;
  localparam int GROUP_NODES   = 7;
  localparam int STATUS_CRIT_POS = 8;

  // ==========================================================================
  // reset values
  localparam logic [5:0] RST_CRIT_CTRL = 6'h00;
  localparam logic [5:0] RST_EN_LOW    = 6'h00;
  localparam logic [7:0] RST_EN_HIGH   = 8'h00;
  localparam logic [6:0] RST_PRIO      = 7'h00;

  // ==========================================================================
  // vector handed to the core
  typedef struct packed {
    logic [15:0] addr;
    logic [1:0]  level;
    logic        critical;
    logic [3:0]  node;
  } ivp_grant_t;

endpackage : ivp_pkg

// [design/ivp_prio_pick.sv]
// picks the highest-level pending node, lowest index first within a level
`timescale 1ns/1ps
module ivp_prio_pick (
  // requests and levels
  input  wire logic [13:0]      req,
  input  wire logic [13:0][1:0] level,
  // winner
  output logic                  found,
  output logic [3:0]            node,
  output logic [1:0]            winLevel
);

  // ==========================================================================
  // search
  always_comb begin
    found    = 1'b0;
    node     = 4'h0;
    winLevel = 2'h0;
    for (int l = 3; l >= 0; l--) begin // R10
      for (int i = 0; i < ivp_pkg::NODES; i++) begin // R11
        if (!found && req[i] && level[i] == 2'(l)) begin
          found    = 1'b1;
          node     = 4'(i);
          winLevel = 2'(l);
        end
      end
    end
  end

  // ==========================================================================
  // checks
  logic higherExists;
  logic earlierExists;
  always_comb begin
    higherExists  = 1'b0;
    earlierExists = 1'b0;
    for (int i = 0; i < ivp_pkg::NODES; i++) begin
      if (req[i] && level[i] > winLevel) higherExists = 1'b1;
      if (req[i] && level[i] == winLevel && 4'(i) < node) earlierExists = 1'b1;
    end
  end

  always_comb begin
    AST_PICK_LEVEL: assert #0 (!found || !higherExists) // R10
      else $error("a higher level request was passed over");
    AST_PICK_ORDER: assert #0 (!found || !earlierExists) // R11
      else $error("polling order broken within a level");
    AST_PICK_FOUND: assert #0 (found == (|req)) // R10
      else $error("pending request not found");
  end

endmodule // ivp_prio_pick

// [design/ivp_interrupt_vector_priority.sv]
// interrupt vectoring and four-level priority arbitration with avalon registers
//
// Functional notes
// R1: maskable nodes vector from 0003 upward by eight, node thirteen at 006B.
// R2: six critical sources share vector 0073, each enabled in critical control.
// R3: each source is gated by its enable; nodes 0-5 low, 6-13 high register.
// R4: node five merges timer 2, divider overflow and LIN into vector 002B.
// R5: each maskable node has one of four levels; critical node has none.
// R6: critical request beats all maskable ones and preempts maskable service.
// R7: levels come from two register pairs, group a and group b.
// R8: service is preempted only by a strictly higher level.
// R9: service at the top maskable level is never preempted by a maskable source.
// R10: simultaneous requests of different levels: highest level wins.
// R11: equal levels: fixed polling order, node zero first, node thirteen last.
// R12: level is high-register bit over low-register bit; three is highest.
// R13: active levels are tracked; core return restores the previous level.
`timescale 1ns/1ps
module ivp_interrupt_vector_priority (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // avalon-mm slave
  input  wire logic [7:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWriteData,
  input  wire logic [3:0]  avsByteEnable,
  output logic [31:0]      avsReadData,
  output logic             avsWaitRequest,
  // peripheral requests, levels held until serviced
  input  wire logic [13:0] nodeReq,
  input  wire logic        timer2Req,
  input  wire logic        fracDivOvfReq,
  input  wire logic        linReq,
  input  wire logic [5:0]  criticalReq,
  // service acknowledges to the peripherals
  output logic [13:0]      nodeServiced,
  output logic             criticalServiced,
  // core side
  output logic             irqReq,
  output ivp_pkg::ivp_grant_t irqGrant,
  input  wire logic        irqAck,
  input  wire logic        irqReturn
);

  // ==========================================================================
  // registers
  logic [5:0]  criticalIrqControlReg;
  logic [5:0]  irqEnableRegLow;
  logic [7:0]  irqEnableRegHigh;
  logic [6:0]  priorityLowBitsA;
  logic [6:0]  priorityHighBitsA;
  logic [6:0]  priorityLowBitsB;
  logic [6:0]  priorityHighBitsB;
  logic [4:0]  inService;
  logic        busAck;
  logic        blank;

  // ==========================================================================
  // avalon decode; one wait state, read data loaded on the first edge
  wire         busReq     = avsRead | avsWrite;
  wire         writeTaken = avsWrite & busAck & avsByteEnable[0];
  wire         selCrit    = avsAddress == ivp_pkg::OFS_CRIT_CTRL;
  wire         selEnLow   = avsAddress == ivp_pkg::OFS_EN_LOW;
  wire         selEnHigh  = avsAddress == ivp_pkg::OFS_EN_HIGH;
  wire         selPloA    = avsAddress == ivp_pkg::OFS_PRIO_LO_A;
  wire         selPhiA    = avsAddress == ivp_pkg::OFS_PRIO_HI_A;
  wire         selPloB    = avsAddress == ivp_pkg::OFS_PRIO_LO_B;
  wire         selPhiB    = avsAddress == ivp_pkg::OFS_PRIO_HI_B;
  wire         selStatus  = avsAddress == ivp_pkg::OFS_STATUS;
  wire [31:0]  statusWord = {18'h0, criticalReq, 3'h0, inService};
  wire [31:0]  readMux    = selCrit   ? {26'h0, criticalIrqControlReg} :
                            selEnLow  ? {26'h0, irqEnableRegLow} :
                            selEnHigh ? {24'h0, irqEnableRegHigh} :
                            selPloA   ? {25'h0, priorityLowBitsA} :
                            selPhiA   ? {25'h0, priorityHighBitsA} :
                            selPloB   ? {25'h0, priorityLowBitsB} :
                            selPhiB   ? {25'h0, priorityHighBitsB} :
                            selStatus ? statusWord : 32'h0;

  assign avsWaitRequest = busReq & ~busAck;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      busAck      <= 1'b0;
      avsReadData <= 32'h0;
    end else begin
      busAck <= busReq & ~busAck;
      if (avsRead && !busAck) avsReadData <= readMux;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      criticalIrqControlReg <= ivp_pkg::RST_CRIT_CTRL;
      irqEnableRegLow       <= ivp_pkg::RST_EN_LOW;
      irqEnableRegHigh      <= ivp_pkg::RST_EN_HIGH;
      priorityLowBitsA      <= ivp_pkg::RST_PRIO;
      priorityHighBitsA     <= ivp_pkg::RST_PRIO;
      priorityLowBitsB      <= ivp_pkg::RST_PRIO;
      priorityHighBitsB     <= ivp_pkg::RST_PRIO;
    end else if (writeTaken) begin
      if (selCrit)   criticalIrqControlReg <= avsWriteData[5:0]; // R2
      if (selEnLow)  irqEnableRegLow       <= avsWriteData[5:0]; // R3
      if (selEnHigh) irqEnableRegHigh      <= avsWriteData[7:0]; // R3
      if (selPloA)   priorityLowBitsA      <= avsWriteData[6:0]; // R7
      if (selPhiA)   priorityHighBitsA     <= avsWriteData[6:0]; // R7
      if (selPloB)   priorityLowBitsB      <= avsWriteData[6:0]; // R7
      if (selPhiB)   priorityHighBitsB     <= avsWriteData[6:0]; // R7
    end
  end

  // ==========================================================================
  // request gathering
  wire [13:0] enableVec  = {irqEnableRegHigh, irqEnableRegLow}; // R3
  wire        node5Merged = nodeReq[5] | timer2Req | fracDivOvfReq | linReq; // R4
  wire [13:0] rawReq     = {nodeReq[13:6], node5Merged, nodeReq[4:0]};
  wire [13:0] pendingVec = rawReq & enableVec; // R3
  wire        critPending = |(criticalReq & criticalIrqControlReg); // R2
  wire [13:0] lowAll     = {priorityLowBitsB, priorityLowBitsA};
  wire [13:0] highAll    = {priorityHighBitsB, priorityHighBitsA};
  logic [13:0][1:0] nodeLevel;

  for (genvar n = 0; n < ivp_pkg::NODES; n++) begin : g_level
    assign nodeLevel[n] = {highAll[n], lowAll[n]}; // R5 R12
  end

  wire        pickFound;
  wire [3:0]  pickNode;
  wire [1:0]  pickLevel;

  ivp_prio_pick u_pick (
    .req      (pendingVec),
    .level    (nodeLevel),
    .found    (pickFound),
    .node     (pickNode),
    .winLevel (pickLevel)
  );

  // ==========================================================================
  // arbitration against the active level
  wire        maskActive = |inService[3:0];
  wire        critActive = inService[ivp_pkg::NMI_SLOT];
  wire [1:0]  curLevel   = inService[3] ? 2'h3 : inService[2] ? 2'h2 :
                           inService[1] ? 2'h1 : 2'h0;
  wire        critWins   = critPending & ~critActive; // R6
  // a maskable winner must beat the active level strictly
  wire        maskWins   = pickFound & ~critActive &
                           (~maskActive | (pickLevel > curLevel)); // R8 R9
  wire        ackTaken   = irqAck & irqReq;
  wire        retTaken   = irqReturn & (|inService);

  ivp_pkg::ivp_grant_t next_grant;
  logic                next_valid;
  always_comb begin
    next_grant       = '0;
    next_valid       = critWins | maskWins;
    if (critWins) begin
      next_grant.addr     = ivp_pkg::NMI_VECTOR; // R2 R6
      next_grant.critical = 1'b1;
    end else begin
      next_grant.addr     = {9'h0, pickNode, ivp_pkg::VEC_LOW_BITS}; // R1
      next_grant.level    = pickLevel;
      next_grant.node     = pickNode;
    end
  end

  // ==========================================================================
  // service tracking; the newest service is always the highest set slot
  wire [4:0] retMask  = critActive ? 5'h10 : 5'h01 << curLevel; // R13
  wire [4:0] ackMask  = irqGrant.critical ? 5'h10 : 5'h01 << irqGrant.level; // R13
  wire [4:0] next_inService = (inService & ~(retTaken ? retMask : 5'h00)) |
                              (ackTaken ? ackMask : 5'h00);
  logic      grantValid;

  // a grant built from pre-ack state is stale for one cycle, so it is hidden
  assign irqReq = grantValid & ~blank;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      inService        <= 5'h00;
      grantValid       <= 1'b0;
      irqGrant         <= '0;
      blank            <= 1'b0;
      nodeServiced     <= 14'h0000;
      criticalServiced <= 1'b0;
    end else begin
      inService        <= next_inService; // R13
      grantValid       <= next_valid;
      irqGrant         <= next_grant;
      blank            <= ackTaken | retTaken;
      criticalServiced <= ackTaken & irqGrant.critical;
      nodeServiced     <= (ackTaken && !irqGrant.critical) ?
                          14'h0001 << irqGrant.node : 14'h0000; // R1
    end
  end

  // ==========================================================================
  // checks
  logic [13:0]      enablePrev;
  logic [13:0][1:0] levelPrev;
  logic [13:0]      otherPrev;
  logic             linOnlyPrev;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      enablePrev  <= 14'h0000;
      levelPrev   <= '0;
      otherPrev   <= 14'h0000;
      linOnlyPrev <= 1'b0;
    end else begin
      enablePrev  <= enableVec;
      levelPrev   <= nodeLevel;
      otherPrev   <= pendingVec & ~14'h0020;
      linOnlyPrev <= linReq & irqEnableRegLow[5] & ~critPending;
    end
  end

  AST_VEC_MAP: assert property (@(posedge ref_clk) disable iff (!reset_n) // R1
    irqReq && !irqGrant.critical |->
      irqGrant.addr == {9'h0, irqGrant.node, ivp_pkg::VEC_LOW_BITS} &&
      irqGrant.addr >= ivp_pkg::VEC_FIRST && irqGrant.addr <= ivp_pkg::VEC_LAST)
    else $error("maskable vector does not match its node");

  AST_CRIT_VEC: assert property (@(posedge ref_clk) disable iff (!reset_n) // R2
    irqReq && irqGrant.critical |-> irqGrant.addr == ivp_pkg::NMI_VECTOR)
    else $error("critical vector is wrong");

  AST_ENABLE_GATE: assert property (@(posedge ref_clk) disable iff (!reset_n) // R3
    irqReq && !irqGrant.critical |-> enablePrev[irqGrant.node])
    else $error("disabled node was vectored");

  AST_NODE5_MERGE: assert property (@(posedge ref_clk) disable iff (!reset_n) // R4
    linOnlyPrev && otherPrev == 14'h0000 && $past(inService) == 5'h00 &&
      !$past(blank) && !$past(ackTaken) |->
      grantValid && irqGrant.addr == ivp_pkg::NODE5_VECTOR)
    else $error("merged node five request not vectored at its address");

  AST_CRIT_FIRST: assert property (@(posedge ref_clk) disable iff (!reset_n) // R6
    critPending && !critActive && !ackTaken && !retTaken |=>
      grantValid && irqGrant.critical)
    else $error("critical request did not take precedence");

  AST_STRICT_PREEMPT: assert property (@(posedge ref_clk) disable iff (!reset_n) // R8
    irqReq && !irqGrant.critical |-> !maskActive || irqGrant.level > curLevel)
    else $error("maskable preemption at same or lower level");

  AST_TOP_LEVEL: assert property (@(posedge ref_clk) disable iff (!reset_n) // R9
    irqReq && inService[3] |-> irqGrant.critical)
    else $error("top level service preempted by a maskable source");

  AST_LEVEL_FORM: assert property (@(posedge ref_clk) disable iff (!reset_n) // R12
    irqReq && !irqGrant.critical |-> irqGrant.level == levelPrev[irqGrant.node])
    else $error("granted level does not match its priority bits");

  AST_ACK_PUSH: assert property (@(posedge ref_clk) disable iff (!reset_n) // R13
    ackTaken && !retTaken |=> $countones(inService) == $countones($past(inService)) + 1
      && !irqReq)
    else $error("acknowledge did not enter a new service level");

  AST_RET_POP: assert property (@(posedge ref_clk) disable iff (!reset_n) // R13
    retTaken && !ackTaken |=> $countones(inService) == $countones($past(inService)) - 1)
    else $error("return did not restore the previous level");

  AST_BUS_WAIT: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(avsRead) |-> avsWaitRequest ##1 !avsWaitRequest)
    else $error("bus answer not after exactly one wait state");

  AST_WRITE_WAIT: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(avsWrite) |-> avsWaitRequest ##1 !avsWaitRequest)
    else $error("write answer not after exactly one wait state");

  AST_READ_UPPER: assert property (@(posedge ref_clk) disable iff (!reset_n)
    avsRead && !avsWaitRequest |-> avsReadData[31:14] == 18'h0)
    else $error("read data carries bits above the register map");

  AST_CRIT_FIELDS: assert property (@(posedge ref_clk) disable iff (!reset_n) // R5
    irqReq && irqGrant.critical |-> irqGrant.level == 2'h0 && irqGrant.node == 4'h0)
    else $error("critical grant carries a level or node");

  AST_CRIT_GATE: assert property (@(posedge ref_clk) disable iff (!reset_n) // R2
    irqReq && irqGrant.critical |-> $past(critPending))
    else $error("critical vector without an enabled critical source");

  AST_CRIT_HOLDS: assert property (@(posedge ref_clk) disable iff (!reset_n) // R6
    critActive |-> !irqReq)
    else $error("request raised during critical service");

  AST_SERVICED_PULSE: assert property (@(posedge ref_clk) disable iff (!reset_n) // R1
    nodeServiced != 14'h0000 |-> $onehot(nodeServiced) && !criticalServiced
      ##1 nodeServiced == 14'h0000)
    else $error("node acknowledge is not a single one-hot pulse");

  AST_RET_BLANK: assert property (@(posedge ref_clk) disable iff (!reset_n) // R13
    retTaken |=> !irqReq)
    else $error("request not hidden after a return");

  COV_CRIT_PREEMPT: cover property (@(posedge ref_clk) disable iff (!reset_n)
    maskActive && ackTaken && irqGrant.critical);
  COV_NESTED: cover property (@(posedge ref_clk) disable iff (!reset_n)
    $countones(inService[3:0]) == 2);
  COV_RETURN: cover property (@(posedge ref_clk) disable iff (!reset_n)
    retTaken ##1 (inService != 5'h00));
  COV_NODE13: cover property (@(posedge ref_clk) disable iff (!reset_n)
    irqReq && irqGrant.addr == ivp_pkg::VEC_LAST);
  COV_TIMER2_MERGE: cover property (@(posedge ref_clk) disable iff (!reset_n)
    irqReq && irqGrant.node == ivp_pkg::NODE_TIMER2 && timer2Req);

endmodule // ivp_interrupt_vector_priority

// [tb/ivp_core_model.sv]
// cpu core model that takes vectors after a programmable delay
`timescale 1ns/1ps
module ivp_core_model (
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  // bench control
  input  wire logic          ackEn,
  input  wire logic [3:0]    ackDelay,
  // block side
  input  wire logic          irqReq,
  input  ivp_pkg::ivp_grant_t irqGrant,
  output logic               irqAck,
  output ivp_pkg::ivp_grant_t taken,
  output logic [7:0]         takenCnt
);
  logic [3:0] waitCnt;

  // ==========================================================================
  // ack handshake: one-cycle pulse, only against a standing request
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqAck <= 1'b0;
      waitCnt <= 4'h0;
      taken <= '0;
      takenCnt <= 8'h00;
    end else if (irqAck) begin
      irqAck <= 1'b0;
      waitCnt <= 4'h0;
      if (irqReq) begin
        taken <= irqGrant;
        takenCnt <= takenCnt + 8'h01;
      end
    end else if (irqReq && ackEn && waitCnt >= ackDelay) begin
      irqAck <= 1'b1;
    end else if (irqReq && ackEn) begin
      waitCnt <= waitCnt + 4'h1;
    end else begin
      // a request that vanishes restarts the delay, like a core mid-instruction
      waitCnt <= 4'h0;
    end
  end
endmodule // ivp_core_model

// [tb/ivp_interrupt_vector_priority_tb.sv]
// self-checking bench for the interrupt vector and priority block
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED %0t value mismatch", $time); end end
module ivp_interrupt_vector_priority_tb;
  logic        ref_clk, reset_n, avsRead, avsWrite, avsWaitRequest;
  logic [7:0]  avsAddress;
  logic [31:0] avsWriteData, avsReadData, rd;
  logic [3:0]  avsByteEnable, ackDelay, be;
  logic [13:0] nodeReq, nodeServiced, lo, hi;
  logic [2:0]  n5src;
  logic [5:0]  criticalReq;
  logic        criticalServiced, irqReq, irqAck, irqReturn, ackEn;
  logic [7:0]  takenCnt;
  ivp_pkg::ivp_grant_t irqGrant, taken;
  int          error_cnt = 0;
  int          tests_run = 0;

  ivp_interrupt_vector_priority u_ivp_interrupt_vector_priority (
    .ref_clk(ref_clk), .reset_n(reset_n), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .nodeReq(nodeReq),
    .timer2Req(n5src[2]), .fracDivOvfReq(n5src[1]), .linReq(n5src[0]),
    .criticalReq(criticalReq), .nodeServiced(nodeServiced),
    .criticalServiced(criticalServiced), .irqReq(irqReq), .irqGrant(irqGrant),
    .irqAck(irqAck), .irqReturn(irqReturn));
  ivp_core_model u_ivp_core_model (
    .ref_clk(ref_clk), .reset_n(reset_n), .ackEn(ackEn), .ackDelay(ackDelay),
    .irqReq(irqReq), .irqGrant(irqGrant), .irqAck(irqAck), .taken(taken),
    .takenCnt(takenCnt));

  // ==========================================================================
  // bus and service helpers
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    avsAddress <= a; avsWrite <= w; avsRead <= !w; avsWriteData <= d; avsByteEnable <= be;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (avsWaitRequest !== 1'b0);
    rd = avsReadData;
    `CHK(i, 2)
    avsWrite <= 1'b0; avsRead <= 1'b0;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task set_en(input logic [13:0] e);
    bus(1'b1, ivp_pkg::OFS_EN_LOW, {26'h0, e[5:0]});
    bus(1'b1, ivp_pkg::OFS_EN_HIGH, {24'h0, e[13:6]});
  endtask
  task set_lv(input int n, input logic [1:0] v);
    lo[n] = v[0];
    hi[n] = v[1];
    bus(1'b1, ivp_pkg::OFS_PRIO_LO_A, {25'h0, lo[6:0]});
    bus(1'b1, ivp_pkg::OFS_PRIO_HI_A, {25'h0, hi[6:0]});
    bus(1'b1, ivp_pkg::OFS_PRIO_LO_B, {25'h0, lo[13:7]});
    bus(1'b1, ivp_pkg::OFS_PRIO_HI_B, {25'h0, hi[13:7]});
  endtask
  task serve(input logic [15:0] a, input logic c, input logic [3:0] n, input logic [1:0] v);
    logic [7:0] c0;
    int i;
    c0 = takenCnt;
    @(posedge ref_clk); ackEn <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(negedge ref_clk);
      if (takenCnt !== c0) break;
    end
    `CHK(takenCnt, c0 + 8'h01)
    `CHK(taken.addr, a)
    `CHK(taken.critical, c)
    `CHK(criticalServiced, c)
    `CHK(nodeServiced, c ? 14'h0 : 14'h1 << n)
    if (!c) begin
      `CHK(taken.node, n)
      `CHK(taken.level, v)
    end
    @(posedge ref_clk); ackEn <= 1'b0;
  endtask
  task quiet(input int k);
    repeat (k) begin
      @(negedge ref_clk);
      `CHK(irqReq, 1'b0)
    end
  endtask
  task ret();
    @(posedge ref_clk); irqReturn <= 1'b1;
    @(posedge ref_clk); irqReturn <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  // ==========================================================================
  // scenarios
  task t_regs();
    int i;
    for (i = 0; i < 8; i++) rdchk(8'(i * 4), 32'h0);
    for (i = 0; i < 7; i++) begin
      bus(1'b1, 8'(i * 4), 32'hffffffff);
      rdchk(8'(i * 4), i == 2 ? 32'hff : (i < 2 ? 32'h3f : 32'h7f));
      bus(1'b1, 8'(i * 4), 32'h0);
    end
    be = 4'he; bus(1'b1, ivp_pkg::OFS_EN_HIGH, 32'hff); be = 4'hf;
    rdchk(ivp_pkg::OFS_EN_HIGH, 32'h0);
    rdchk(8'h20, 32'h0);
    rdchk(8'h02, 32'h0);
    bus(1'b1, ivp_pkg::OFS_STATUS, 32'hffffffff);
    @(posedge ref_clk); criticalReq <= 6'h2a;
    rdchk(ivp_pkg::OFS_STATUS, 32'h2a00);
    @(posedge ref_clk); criticalReq <= 6'h00;
  endtask
  task t_vec();
    int n;
    @(posedge ref_clk); nodeReq <= 14'h3fff;
    for (n = 0; n < 14; n++) begin
      set_en(14'h1 << n);
      serve(16'h0003 + 16'(8 * n), 1'b0, 4'(n), 2'h0);
      set_en(14'h0);
      ret();
      quiet(3);
    end
    @(posedge ref_clk); nodeReq <= 14'h0;
  endtask
  task t_node5();
    int i;
    set_en(14'h0020);
    for (i = 0; i < 3; i++) begin
      @(posedge ref_clk); n5src <= 3'h1 << i;
      serve(ivp_pkg::NODE5_VECTOR, 1'b0, 4'h5, 2'h0);
      @(posedge ref_clk); n5src <= 3'h0;
      ret();
    end
    set_en(14'h0);
  endtask
  task t_crit();
    int i;
    ackDelay <= 4'h3;
    for (i = 0; i < 6; i++) begin
      bus(1'b1, ivp_pkg::OFS_CRIT_CTRL, 32'h3f ^ (32'h1 << i));
      @(posedge ref_clk); criticalReq <= 6'h1 << i;
      quiet(4);
      bus(1'b1, ivp_pkg::OFS_CRIT_CTRL, 32'h1 << i);
      serve(ivp_pkg::NMI_VECTOR, 1'b1, 4'h0, 2'h0);
      @(posedge ref_clk); criticalReq <= 6'h0;
      ret();
    end
    ackDelay <= 4'h0;
  endtask
  task t_prio();
    bus(1'b1, ivp_pkg::OFS_CRIT_CTRL, 32'h1);
    set_lv(13, 2'h3);
    set_en(14'h2001);
    @(posedge ref_clk); nodeReq <= 14'h2001;
    serve(ivp_pkg::VEC_LAST, 1'b0, 4'hd, 2'h3);
    @(posedge ref_clk); nodeReq <= 14'h0001;
    quiet(6);
    @(posedge ref_clk); criticalReq <= 6'h01;
    serve(ivp_pkg::NMI_VECTOR, 1'b1, 4'h0, 2'h0);
    rdchk(ivp_pkg::OFS_STATUS, 32'h0118);
    @(posedge ref_clk); criticalReq <= 6'h00;
    ret();
    quiet(6);
    rdchk(ivp_pkg::OFS_STATUS, 32'h0008);
    ret();
    serve(ivp_pkg::VEC_FIRST, 1'b0, 4'h0, 2'h0);
    @(posedge ref_clk); nodeReq <= 14'h0;
    ret();
    rdchk(ivp_pkg::OFS_STATUS, 32'h0000);
    bus(1'b1, ivp_pkg::OFS_CRIT_CTRL, 32'h0);
  endtask
  task t_equal();
    set_lv(4, 2'h2); set_lv(9, 2'h2); set_lv(11, 2'h1); set_lv(7, 2'h3);
    set_en(14'h0a90);
    @(posedge ref_clk); nodeReq <= 14'h0a10;
    serve(16'h0023, 1'b0, 4'h4, 2'h2);
    @(posedge ref_clk); nodeReq <= 14'h0a00;
    quiet(6);
    @(posedge ref_clk); nodeReq <= 14'h0a80;
    serve(16'h003b, 1'b0, 4'h7, 2'h3);
    @(posedge ref_clk); nodeReq <= 14'h0a00;
    ret();
    quiet(4);
    ret();
    serve(16'h004b, 1'b0, 4'h9, 2'h2);
    @(posedge ref_clk); nodeReq <= 14'h0800;
    ret();
    serve(16'h005b, 1'b0, 4'hb, 2'h1);
    @(posedge ref_clk); nodeReq <= 14'h0;
    ret();
    set_en(14'h0);
  endtask

  task report_and_stop();
    if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // clock, reset, sequence and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    {reset_n, avsRead, avsWrite, irqReturn, ackEn} = 5'h0;
    {avsAddress, avsWriteData, nodeReq, n5src, criticalReq} = '0;
    {lo, hi} = '0;
    avsByteEnable = 4'hf; be = 4'hf; ackDelay = 4'h0;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_regs(); t_vec(); t_node5(); t_crit(); t_prio(); t_equal();
    report_and_stop();
  end
  // whole run is under a thousand cycles; allow ample margin
  initial begin
    #400000;
    error_cnt++;
    report_and_stop();
  end
endmodule // ivp_interrupt_vector_priority_tb
